// >>> design/gpio_de_defs.svh
// register map, reset values and pin positions of gpio ports d and e
`ifndef GPIO_DE_DEFS_SVH
`define GPIO_DE_DEFS_SVH
// ****************************************
// register byte addresses
// ****************************************
`define GPIO_D_CON_ADDR 32'h56000030
`define GPIO_D_DAT_ADDR 32'h56000034
`define GPIO_D_PUP_ADDR 32'h56000038
`define GPIO_E_CON_ADDR 32'h56000040
`define GPIO_E_DAT_ADDR 32'h56000044
`define GPIO_E_PUP_ADDR 32'h56000048
// ****************************************
// reset values and writable masks
// ****************************************
`define GPIO_CON_RESET 32'h00000000
`define GPIO_DAT_RESET 16'h0000
`define GPIO_D_PUP_RESET 16'hf000
`define GPIO_E_PUP_RESET 16'h0000
`define GPIO_D_PUP_MASK 16'hffff
`define GPIO_E_PUP_MASK 16'h3fff
// ****************************************
// pin positions of shared functions
// ****************************************
`define GPIO_D_SS0_PIN 15
`define GPIO_D_SS1_PIN 14
`define GPIO_D_SPI1_CLK_PIN 10
`define GPIO_D_SPI1_MO_PIN 9
`define GPIO_D_SPI1_MI_PIN 8
`define GPIO_E_SDA_PIN 15
`define GPIO_E_SCL_PIN 14
`define GPIO_E_SPI0_CLK_PIN 13
`define GPIO_E_SPI0_MO_PIN 12
`define GPIO_E_SPI0_MI_PIN 11
`define GPIO_E_CARD_D0_PIN 7
`define GPIO_E_CARD_CMD_PIN 6
`define GPIO_E_CARD_CLK_PIN 5
`define GPIO_E_AUD_OUT_PIN 4
`define GPIO_E_AUD_IN_PIN 3
`define GPIO_E_CODEC_CLK_PIN 2
`define GPIO_E_BIT_CLK_PIN 1
`define GPIO_E_LR_CLK_PIN 0
`endif

// >>> design/gpio_de_pkg.sv
// types shared by the port d and e pin logic
package gpio_de_pkg;
  // two-bit pin function code
  typedef enum logic [1:0] {
    PIN_INPUT = 2'b00,
    PIN_OUTPUT = 2'b01,
    PIN_ALT_A = 2'b10,
    PIN_ALT_B = 2'b11
  } pinMode_t;
  // one peripheral drive: value and enable
  typedef struct packed {
    logic o;
    logic oe;
  } drive_t;
  // pad controls of one 16-pin port
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] pullupEn;
  } padBus_t;
  // peripheral outputs towards the pads; lcdVideoData[n] is video bit n+8
  typedef struct packed {
    logic [15:0] lcdVideoData;
    drive_t spi1Clock;
    drive_t spi1MasterOut;
    drive_t spi1MasterIn;
    drive_t spi0Clock;
    drive_t spi0MasterOut;
    drive_t spi0MasterIn;
    drive_t twowireData;
    drive_t twowireClock;
    drive_t [3:0] cardData;
    drive_t cardCommand;
    drive_t cardClock;
    drive_t audioSerialOut;
    drive_t codecMasterClock;
    drive_t audioBitClock;
    drive_t audioLrClock;
  } periphOut_t;
  // pad levels routed back to the peripherals
  typedef struct packed {
    logic spi0SlaveSelect;
    logic spi1SlaveSelect;
    logic spi1Clock;
    logic spi1MasterOut;
    logic spi1MasterIn;
    logic spi0Clock;
    logic spi0MasterOut;
    logic spi0MasterIn;
    logic twowireData;
    logic twowireClock;
    logic [3:0] cardData;
    logic cardCommand;
    logic audioSerialIn;
    logic audioSerialInAlt;
    logic audioBitClock;
    logic audioLrClock;
  } periphIn_t;
  // level a peripheral sees while no pin is routed to it
  localparam periphIn_t PERIPH_IN_IDLE = '{spi0SlaveSelect: 1'b1, spi1SlaveSelect: 1'b1,
    twowireData: 1'b1, twowireClock: 1'b1, default: '0};
endpackage

// >>> design/gpio_pin_cell.sv
// one pad: function mux, open-drain option and registered pad controls
`timescale 1ns/100ps
module gpio_pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0,
  parameter bit HAS_PULLUP = 1'b1
) (
  input logic sys_clk,
  input logic nrst,
  input gpio_de_pkg::pinMode_t mode,
  input logic dataBit,
  input gpio_de_pkg::drive_t altA,
  input gpio_de_pkg::drive_t altB,
  input logic pullupDis,
  output logic padOut_q,
  output logic padOe_q,
  output logic padPullupEn_q
);
  logic padOut_d;
  logic padOe_d;

  // function select; input mode releases the pad
  always_comb begin
    padOut_d = 1'b0;
    padOe_d = 1'b0;
    case (mode)
      gpio_de_pkg::PIN_INPUT: padOe_d = 1'b0;
      gpio_de_pkg::PIN_OUTPUT: begin
        padOut_d = dataBit;
        padOe_d = 1'b1;
      end
      gpio_de_pkg::PIN_ALT_A: begin
        padOut_d = altA.o;
        padOe_d = altA.oe;
      end
      gpio_de_pkg::PIN_ALT_B: begin
        padOut_d = altB.o;
        padOe_d = altB.oe;
      end
      default: padOe_d = 1'b0;
    endcase
    // open-drain pads only ever pull low
    if (OPEN_DRAIN) begin
      padOe_d = padOe_d & ~padOut_d;
      padOut_d = 1'b0;
    end
  end

  // registered so that pad controls never glitch while the mux settles
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      padOut_q <= 1'b0;
      padOe_q <= 1'b0;
      padPullupEn_q <= 1'b0;
    end else begin
      padOut_q <= padOut_d;
      padOe_q <= padOe_d;
      padPullupEn_q <= HAS_PULLUP & ~pullupDis;
    end
  end
endmodule

// >>> design/gpio_port_regs.sv
// configuration, data and pull-up disable registers of one port
`timescale 1ns/100ps
`include "gpio_de_defs.svh"
module gpio_port_regs #(
  parameter logic [15:0] PUP_RESET = `GPIO_D_PUP_RESET,
  parameter logic [15:0] PUP_MASK = `GPIO_D_PUP_MASK
) (
  input logic sys_clk,
  input logic nrst,
  input logic wrCon,
  input logic wrDat,
  input logic wrPup,
  input logic [31:0] wdata,
  output logic [31:0] con_q,
  output logic [15:0] dat_q,
  output logic [15:0] pup_q
);
  // all pins come up as inputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      con_q <= `GPIO_CON_RESET;
    end else if (wrCon) begin
      con_q <= wdata;
    end
  end

  // reset value is a choice; software must not rely on it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dat_q <= `GPIO_DAT_RESET;
    end else if (wrDat) begin
      dat_q <= wdata[15:0];
    end
  end

  // bits without a pull-up stay zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pup_q <= PUP_RESET;
    end else if (wrPup) begin
      pup_q <= wdata[15:0] & PUP_MASK;
    end
  end
endmodule

// >>> design/gpio_ports_d_e_pin_mux.sv
// gpio ports d and e: apb registers, pin function mux and input routing
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`include "gpio_de_defs.svh"
module gpio_ports_d_e_pin_mux (
  input logic sys_clk,
  input logic nrst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [15:0] padInD,
  input logic [15:0] padInE,
  output gpio_de_pkg::padBus_t padD,
  output gpio_de_pkg::padBus_t padE,
  input gpio_de_pkg::periphOut_t periphOut,
  output gpio_de_pkg::periphIn_t periphIn
);
  logic [31:0] conD;
  logic [31:0] conE;
  logic [15:0] datD;
  logic [15:0] datE;
  logic [15:0] pupD;
  logic [15:0] pupE;
  logic [15:0] datRdD;
  logic [15:0] datRdE;
  logic [15:0] outModeD;
  logic [15:0] inModeD;
  logic [31:0] rdData;
  logic addrHit;
  logic accessWait;
  logic commit;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  gpio_de_pkg::pinMode_t modeD [16];
  gpio_de_pkg::pinMode_t modeE [16];
  gpio_de_pkg::drive_t [15:0] altAD;
  gpio_de_pkg::drive_t [15:0] altBD;
  gpio_de_pkg::drive_t [15:0] altAE;
  gpio_de_pkg::drive_t [15:0] altBE;
  gpio_de_pkg::periphIn_t perIn_q;
  wire [15:0] padOutD;
  wire [15:0] padOeD;
  wire [15:0] padPuD;
  wire [15:0] padOutE;
  wire [15:0] padOeE;
  wire [15:0] padPuE;

  // ****************************************
  // apb slave
  // ****************************************

  // one wait state: data is latched in the first access cycle
  assign accessWait = psel & penable & ~pready_q;
  // a write lands only at the edge that completes the transfer
  assign commit = psel & penable & pready_q & pwrite;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= accessWait;
    end
  end

  // read data and error stand only while pready is high
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (accessWait) begin
      prdata_q <= pwrite ? 32'h00000000 : rdData;
      pslverr_q <= ~addrHit;
    end else begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // address decode and read mux; unmapped reads return zero
  always_comb begin
    rdData = 32'h00000000;
    addrHit = 1'b1;
    case (paddr)
      `GPIO_D_CON_ADDR: rdData = conD;
      `GPIO_D_DAT_ADDR: rdData = {16'h0000, datRdD};
      `GPIO_D_PUP_ADDR: rdData = {16'h0000, pupD};
      `GPIO_E_CON_ADDR: rdData = conE;
      `GPIO_E_DAT_ADDR: rdData = {16'h0000, datRdE};
      `GPIO_E_PUP_ADDR: rdData = {16'h0000, pupE};
      default: addrHit = 1'b0;
    endcase
  end

  // ****************************************
  // port registers
  // ****************************************

  gpio_port_regs #(.PUP_RESET(`GPIO_D_PUP_RESET), .PUP_MASK(`GPIO_D_PUP_MASK)) regsD (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wrCon(commit && paddr == `GPIO_D_CON_ADDR),
    .wrDat(commit && paddr == `GPIO_D_DAT_ADDR),
    .wrPup(commit && paddr == `GPIO_D_PUP_ADDR),
    .wdata(pwdata),
    .con_q(conD),
    .dat_q(datD),
    .pup_q(pupD)
  );

  gpio_port_regs #(.PUP_RESET(`GPIO_E_PUP_RESET), .PUP_MASK(`GPIO_E_PUP_MASK)) regsE (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wrCon(commit && paddr == `GPIO_E_CON_ADDR),
    .wrDat(commit && paddr == `GPIO_E_DAT_ADDR),
    .wrPup(commit && paddr == `GPIO_E_PUP_ADDR),
    .wdata(pwdata),
    .con_q(conE),
    .dat_q(datE),
    .pup_q(pupE)
  );

  // ****************************************
  // per-pin modes and data readback
  // ****************************************

  // output pins read back the data bit, all others the pad level
  for (genvar g = 0; g < 16; g++) begin : gModes
    assign modeD[g] = gpio_de_pkg::pinMode_t'(conD[2*g +: 2]);
    assign modeE[g] = gpio_de_pkg::pinMode_t'(conE[2*g +: 2]);
    assign datRdD[g] = (modeD[g] == gpio_de_pkg::PIN_OUTPUT) ? datD[g] : padInD[g];
    assign datRdE[g] = (modeE[g] == gpio_de_pkg::PIN_OUTPUT) ? datE[g] : padInE[g];
    assign outModeD[g] = (modeD[g] == gpio_de_pkg::PIN_OUTPUT);
    assign inModeD[g] = (modeD[g] == gpio_de_pkg::PIN_INPUT);
  end

  // ****************************************
  // alternate function drive
  // ****************************************

  // reserved and input-only functions leave the pad released
  always_comb begin
    altBD = '0;
    altAE = '0;
    altBE = '0;
    for (int i = 0; i < 16; i++) begin
      altAD[i] = '{o: periphOut.lcdVideoData[i], oe: 1'b1};
    end
    altBD[`GPIO_D_SPI1_CLK_PIN] = periphOut.spi1Clock;
    altBD[`GPIO_D_SPI1_MO_PIN] = periphOut.spi1MasterOut;
    altBD[`GPIO_D_SPI1_MI_PIN] = periphOut.spi1MasterIn;
    altAE[`GPIO_E_SDA_PIN] = periphOut.twowireData;
    altAE[`GPIO_E_SCL_PIN] = periphOut.twowireClock;
    altAE[`GPIO_E_SPI0_CLK_PIN] = periphOut.spi0Clock;
    altAE[`GPIO_E_SPI0_MO_PIN] = periphOut.spi0MasterOut;
    altAE[`GPIO_E_SPI0_MI_PIN] = periphOut.spi0MasterIn;
    for (int j = 0; j < 4; j++) begin
      altAE[`GPIO_E_CARD_D0_PIN + j] = periphOut.cardData[j];
    end
    altAE[`GPIO_E_CARD_CMD_PIN] = periphOut.cardCommand;
    altAE[`GPIO_E_CARD_CLK_PIN] = periphOut.cardClock;
    altAE[`GPIO_E_AUD_OUT_PIN] = periphOut.audioSerialOut;
    altAE[`GPIO_E_CODEC_CLK_PIN] = periphOut.codecMasterClock;
    altAE[`GPIO_E_BIT_CLK_PIN] = periphOut.audioBitClock;
    altAE[`GPIO_E_LR_CLK_PIN] = periphOut.audioLrClock;
  end

  // ****************************************
  // pad cells
  // ****************************************

  // the two-wire pads of port e are open-drain without a pull-up
  for (genvar g = 0; g < 16; g++) begin : gCells
    gpio_pin_cell #(.OPEN_DRAIN(1'b0), .HAS_PULLUP(1'b1)) cellD (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .mode(modeD[g]),
      .dataBit(datD[g]),
      .altA(altAD[g]),
      .altB(altBD[g]),
      .pullupDis(pupD[g]),
      .padOut_q(padOutD[g]),
      .padOe_q(padOeD[g]),
      .padPullupEn_q(padPuD[g])
    );
    gpio_pin_cell #(.OPEN_DRAIN(g >= `GPIO_E_SCL_PIN), .HAS_PULLUP(g < `GPIO_E_SCL_PIN)) cellE (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .mode(modeE[g]),
      .dataBit(datE[g]),
      .altA(altAE[g]),
      .altB(altBE[g]),
      .pullupDis(pupE[g]),
      .padOut_q(padOutE[g]),
      .padOe_q(padOeE[g]),
      .padPullupEn_q(padPuE[g])
    );
  end

  assign padD = {padOutD, padOeD, padPuD};
  assign padE = {padOutE, padOeE, padPuE};

  // ****************************************
  // peripheral input routing
  // ****************************************

  // pad level when the pin carries the wanted function, idle level otherwise
  function automatic logic route(gpio_de_pkg::pinMode_t m, gpio_de_pkg::pinMode_t want, logic pin, logic idle);
    return (m == want) ? pin : idle;
  endfunction

  localparam gpio_de_pkg::periphIn_t IDLE = gpio_de_pkg::PERIPH_IN_IDLE;
  localparam gpio_de_pkg::pinMode_t ALTA = gpio_de_pkg::PIN_ALT_A;
  localparam gpio_de_pkg::pinMode_t ALTB = gpio_de_pkg::PIN_ALT_B;

  // select0 may sit on two pins; port d is checked first
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      perIn_q <= gpio_de_pkg::PERIPH_IN_IDLE;
    end else begin
      perIn_q.spi0SlaveSelect <= route(modeD[`GPIO_D_SS0_PIN], ALTB, padInD[`GPIO_D_SS0_PIN],
        route(modeE[`GPIO_E_AUD_IN_PIN], ALTB, padInE[`GPIO_E_AUD_IN_PIN], IDLE.spi0SlaveSelect));
      perIn_q.spi1SlaveSelect <= route(modeD[`GPIO_D_SS1_PIN], ALTB, padInD[`GPIO_D_SS1_PIN],
        IDLE.spi1SlaveSelect);
      perIn_q.spi1Clock <= route(modeD[`GPIO_D_SPI1_CLK_PIN], ALTB, padInD[`GPIO_D_SPI1_CLK_PIN],
        IDLE.spi1Clock);
      perIn_q.spi1MasterOut <= route(modeD[`GPIO_D_SPI1_MO_PIN], ALTB, padInD[`GPIO_D_SPI1_MO_PIN],
        IDLE.spi1MasterOut);
      perIn_q.spi1MasterIn <= route(modeD[`GPIO_D_SPI1_MI_PIN], ALTB, padInD[`GPIO_D_SPI1_MI_PIN], IDLE.spi1MasterIn);
      perIn_q.spi0Clock <= route(modeE[`GPIO_E_SPI0_CLK_PIN], ALTA, padInE[`GPIO_E_SPI0_CLK_PIN],
        IDLE.spi0Clock);
      perIn_q.spi0MasterOut <= route(modeE[`GPIO_E_SPI0_MO_PIN], ALTA, padInE[`GPIO_E_SPI0_MO_PIN],
        IDLE.spi0MasterOut);
      perIn_q.spi0MasterIn <= route(modeE[`GPIO_E_SPI0_MI_PIN], ALTA, padInE[`GPIO_E_SPI0_MI_PIN], IDLE.spi0MasterIn);
      perIn_q.twowireData <= route(modeE[`GPIO_E_SDA_PIN], ALTA, padInE[`GPIO_E_SDA_PIN], IDLE.twowireData);
      perIn_q.twowireClock <= route(modeE[`GPIO_E_SCL_PIN], ALTA, padInE[`GPIO_E_SCL_PIN], IDLE.twowireClock);
      for (int j = 0; j < 4; j++) begin
        perIn_q.cardData[j] <= route(modeE[`GPIO_E_CARD_D0_PIN + j], ALTA, padInE[`GPIO_E_CARD_D0_PIN + j],
          IDLE.cardData[j]);
      end
      perIn_q.cardCommand <= route(modeE[`GPIO_E_CARD_CMD_PIN], ALTA, padInE[`GPIO_E_CARD_CMD_PIN], IDLE.cardCommand);
      perIn_q.audioSerialIn <= route(modeE[`GPIO_E_AUD_IN_PIN], ALTA, padInE[`GPIO_E_AUD_IN_PIN],
        IDLE.audioSerialIn);
      perIn_q.audioSerialInAlt <= route(modeE[`GPIO_E_AUD_OUT_PIN], ALTB, padInE[`GPIO_E_AUD_OUT_PIN],
        IDLE.audioSerialInAlt);
      perIn_q.audioBitClock <= route(modeE[`GPIO_E_BIT_CLK_PIN], ALTA, padInE[`GPIO_E_BIT_CLK_PIN],
        IDLE.audioBitClock);
      perIn_q.audioLrClock <= route(modeE[`GPIO_E_LR_CLK_PIN], ALTA, padInE[`GPIO_E_LR_CLK_PIN], IDLE.audioLrClock);
    end
  end

  assign periphIn = perIn_q;

  // ****************************************
  // assertions
  // ****************************************

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence conWrD;
    psel && penable && pready_q && pwrite && paddr == `GPIO_D_CON_ADDR;
  endsequence

  sequence datRdSetupD;
    psel && !penable && !pwrite && paddr == `GPIO_D_DAT_ADDR;
  endsequence

  sequence firstAccess;
    psel && penable && !pready_q;
  endsequence

  sequence datWrD;
    psel && penable && pready_q && pwrite && paddr == `GPIO_D_DAT_ADDR;
  endsequence

  config_write_a: assert property (conWrD |=> conD == $past(pwdata))
    else $error("port d configuration write not stored");

  lcd_data_a: assert property (modeD[0] == ALTA
    |=> padD.out[0] == $past(periphOut.lcdVideoData[0]) && padD.oe[0])
    else $error("port d pin 0 does not carry video bit 8");

  select_priority_a: assert property (modeD[15] == ALTB |=> periphIn.spi0SlaveSelect == $past(padInD[15]))
    else $error("select0 not taken from port d pin 15");

  spi1_clock_a: assert property (modeD[10] == ALTB |=> padD.out[10] == $past(periphOut.spi1Clock.o))
    else $error("spi1 clock not on port d pin 10");

  reset_input_a: assert property ($rose(nrst) |-> conD == 32'h00000000 && conE == 32'h00000000)
    else $error("pins not all inputs after reset");

  twowire_pad_a: assert property (modeE[15] == ALTA |=> !padE.out[15] && !padE.pullupEn[15]
    && padE.oe[15] == $past(periphOut.twowireData.oe && !periphOut.twowireData.o))
    else $error("two-wire data pad not open-drain");

  spi0_clock_a: assert property (modeE[13] == ALTA |=> padE.out[13] == $past(periphOut.spi0Clock.o))
    else $error("spi0 clock not on port e pin 13");

  card_clock_a: assert property (modeE[5] == ALTA |=> padE.out[5] == $past(periphOut.cardClock.o))
    else $error("card clock not on port e pin 5");

  lr_clock_a: assert property (modeE[0] == ALTA |=> padE.out[0] == $past(periphOut.audioLrClock.o))
    else $error("lr clock not on port e pin 0");

  alt_audio_in_a: assert property (modeE[4] == ALTB |=> periphIn.audioSerialInAlt == $past(padInE[4]))
    else $error("alternate audio input not routed");

  input_read_a: assert property (datRdSetupD ##1 firstAccess
    |=> pready_q && ((prdata_q[15:0] ^ $past(padInD)) & $past(inModeD)) == 16'h0000)
    else $error("input pin read does not show pad level");

  output_drive_a: assert property (1'b1 |=> (padD.oe & $past(outModeD)) == $past(outModeD)
    && ((padD.out ^ $past(datD)) & $past(outModeD)) == 16'h0000)
    else $error("output pin not driven from data bit");

  // pads still sit in reset at the release edge, so only edges seen out of reset start a check
  pullup_follow_a: assert property (nrst |=> padD.pullupEn == ~$past(pupD))
    else $error("port d pull-up enable does not follow register");

  pullup_reset_a: assert property ($rose(nrst) |-> pupD == 16'hf000 && pupE == 16'h0000)
    else $error("pull-up disable reset value wrong");

  no_pullup_e_a: assert property (pupE[15:14] == 2'b00 && padE.pullupEn[15:14] == 2'b00)
    else $error("port e pins 15 and 14 show pull-up control");

  shared_select_a: assert property (modeD[15] != ALTB && modeE[3] == ALTB
    |=> periphIn.spi0SlaveSelect == $past(padInE[3]))
    else $error("select0 not taken from port e pin 3");

  data_write_a: assert property (datWrD |=> datD == $past(pwdata[15:0]))
    else $error("port d data write not stored");

  input_release_a: assert property (nrst |=> (padD.oe & $past(inModeD)) == 16'h0000)
    else $error("input pin of port d still driven");

  spi1_select_a: assert property (modeD[14] == ALTB |=> periphIn.spi1SlaveSelect == $past(padInD[14]))
    else $error("select1 not taken from port d pin 14");

  twowire_output_a: assert property (modeE[14] == gpio_de_pkg::PIN_OUTPUT
    |=> !padE.out[14] && padE.oe[14] == !$past(datE[14]))
    else $error("two-wire clock pad not open-drain in output mode");

  audio_out_a: assert property (modeE[4] == ALTA
    |=> padE.out[4] == $past(periphOut.audioSerialOut.o) && padE.oe[4] == $past(periphOut.audioSerialOut.oe))
    else $error("audio serial output not on port e pin 4");

  pullup_e_follow_a: assert property (nrst |=> padE.pullupEn[13:0] == ~$past(pupE[13:0]))
    else $error("port e pull-up enable does not follow register");
endmodule

// >>> bench/gpio_board_model.sv
// board-level model of the devices and wiring on the pins of ports d and e
`timescale 1ns/100ps
module gpio_board_model (
  input logic sys_clk,
  input gpio_de_pkg::padBus_t padD,
  input gpio_de_pkg::padBus_t padE,
  input logic [15:0] extD,
  input logic [15:0] extE,
  input logic [15:0] extEnD,
  input logic [15:0] extEnE,
  output logic [15:0] padInD,
  output logic [15:0] padInE
);
  logic [15:0] floatPat_q = 16'h5a5a;
  // an undriven pin without pull-up wanders, so a stale level never reads back
  always_ff @(posedge sys_clk) begin
    floatPat_q <= ~floatPat_q;
  end
  // wire level: pad drive, then board drive, then pull-up or floating
  assign padInD = (padD.oe & padD.out) | (~padD.oe & extEnD & extD) |
    (~padD.oe & ~extEnD & (padD.pullupEn | floatPat_q));
  // two-wire lines carry board pull-ups because the pads offer none
  assign padInE = (padE.oe & padE.out) | (~padE.oe & extEnE & extE) |
    (~padE.oe & ~extEnE & (padE.pullupEn | 16'hc000 | floatPat_q));
endmodule

// >>> bench/gpio_ports_d_e_pin_mux_bench.sv
// self-checking bench for the port d and e pin logic
`timescale 1ns/100ps
`include "gpio_de_defs.svh"
module gpio_ports_d_e_pin_mux_bench;
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [15:0] padInD, padInE, extD = 0, extE = 0, extEnD = 0, extEnE = 0;
  gpio_de_pkg::padBus_t padD, padE;
  gpio_de_pkg::periphOut_t periphOut = '0;
  gpio_de_pkg::periphIn_t periphIn;
  int fail_count = 0, checks = 0, cyc = 0;
  gpio_ports_d_e_pin_mux dut_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .padInD(padInD), .padInE(padInE), .padD(padD), .padE(padE),
    .periphOut(periphOut), .periphIn(periphIn));
  gpio_board_model board_u (.sys_clk(sys_clk), .padD(padD), .padE(padE), .extD(extD), .extE(extE),
    .extEnD(extEnD), .extEnE(extEnE), .padInD(padInD), .padInE(padInE));
  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // a hung handshake would otherwise stall the run forever
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  // pads follow a register one edge after its commit
  task automatic settle();
    repeat (3) @(posedge sys_clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    apb(0, `GPIO_D_CON_ADDR, 0); chk(rd, 32'h0);
    apb(0, `GPIO_E_CON_ADDR, 0); chk(rd, 32'h0);
    apb(0, `GPIO_D_PUP_ADDR, 0); chk(rd, 32'hf000);
    apb(0, `GPIO_E_PUP_ADDR, 0); chk(rd, 32'h0);
    chk({padD.pullupEn, padE.pullupEn}, 32'h0fff3fff);
    chk({padD.oe, padE.oe}, 32'h0);
  endtask
  task automatic t_output();
    apb(1, `GPIO_D_CON_ADDR, 32'h55555555);
    apb(1, `GPIO_D_DAT_ADDR, 32'ha5c3);
    apb(1, `GPIO_E_CON_ADDR, 32'h50000000);
    apb(1, `GPIO_E_DAT_ADDR, 32'h4000);
    settle();
    chk(padD.oe, 32'hffff);
    chk(padD.out, 32'ha5c3);
    apb(0, `GPIO_D_DAT_ADDR, 0); chk(rd, 32'ha5c3);
    chk({padE.oe[15:14], padE.out[15:14], padInE[15:14]}, 32'h21);
  endtask
  task automatic t_input();
    apb(1, `GPIO_D_CON_ADDR, 32'h0);
    extD <= 16'h1234;
    extEnD <= 16'hffff;
    apb(1, `GPIO_D_PUP_ADDR, 32'h00ff);
    settle();
    apb(0, `GPIO_D_DAT_ADDR, 0); chk(rd, 32'h1234);
    chk(padD.pullupEn, 32'hff00);
  endtask
  task automatic t_alt();
    extEnD <= 16'h0;
    periphOut.lcdVideoData <= 16'hbeef;
    apb(1, `GPIO_D_CON_ADDR, 32'haaaaaaaa);
    settle();
    chk({padD.oe, padD.out}, 32'hffffbeef);
    // only legal second functions are selected on each pin
    apb(1, `GPIO_D_CON_ADDR, 32'hf03f0000);
    apb(1, `GPIO_E_CON_ADDR, 32'h00800ac0);
    extD <= 16'h0100;
    extEnD <= 16'hc100;
    extE <= 16'h0808;
    extEnE <= 16'h0808;
    periphOut.spi1Clock <= 2'b11;
    periphOut.cardClock <= 2'b11;
    periphOut.audioSerialOut <= 2'b11;
    settle();
    chk({padD.oe[10], padD.out[10], periphIn.spi1SlaveSelect, periphIn.spi1MasterIn}, 32'hd);
    chk(periphIn.spi0SlaveSelect, 32'h0);
    chk(periphIn.spi0MasterIn, 32'h1);
    chk(padE.oe[5], 32'h1);
    chk(padE.out[5], 32'h1);
    chk({padE.oe[4], padE.out[4]}, 32'h3);
    // port d pin 15 released: select0 must follow port e pin 3 low, not the idle high
    apb(1, `GPIO_D_CON_ADDR, 32'h303f0000);
    extE <= 16'h0800;
    settle();
    chk(periphIn.spi0SlaveSelect, 32'h0);
  endtask
  task automatic t_unmapped();
    apb(0, 32'h5600003c, 0);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    apb(1, `GPIO_E_PUP_ADDR, 32'hffff);
    apb(0, `GPIO_E_PUP_ADDR, 0); chk(rd, 32'h3fff);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1;
    settle();
    t_reset();
    t_output();
    t_input();
    t_alt();
    t_unmapped();
    stop_test();
  end
endmodule
